// ---- logic/uaf_pkg.sv ----
package uaf_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PWR = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_OWN = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_CSEL = 8'h14;
    localparam logic [7:0] OFS_IST = 8'h18;
    localparam logic [7:0] OFS_IMSK = 8'h1C;
    // Serial control register bits
    localparam int CB_TOP = 7;
    localparam int CB_SM1 = 6;
    localparam int CB_MP = 5;
    localparam int CB_REN = 4;
    localparam int CB_TB8 = 3;
    localparam int CB_RB8 = 2;
    localparam int CB_TI = 1;
    localparam int CB_RI = 0;
    // Power control, clock select and interrupt bits
    localparam int PB_DBL = 7;
    localparam int PB_FCS = 6;
    localparam int SB_RXC = 0;
    localparam int SB_TXC = 1;
    localparam int IB_RX = 0;
    localparam int IB_TX = 1;
    localparam int IB_FE = 2;
    // Reset values
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic TXD_IDLE = 1'b1;
    // Modes, timing counts and bus response codes
    localparam logic [1:0] MODE0 = 2'h0;
    localparam logic [1:0] MODE2 = 2'h2;
    localparam logic [3:0] M0_LAST = 4'hB;
    localparam logic [3:0] M0_HALF = 4'h6;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] FR_LEN8 = 4'hA;
    localparam logic [3:0] FR_LEN9 = 4'hB;
    localparam logic [3:0] FR_STOP = 4'h1;
    localparam logic [1:0] M2_DIV = 2'h3;
    localparam logic [1:0] M2_DIV_DBL = 2'h1;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef enum logic [2:0]
    {
        RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
        RX_NINE = 3'h2, RX_STOP = 3'h6, RX_SHIFT = 3'h4
    } uaf_rx_st_t;

    typedef enum logic [1:0]
    {
        TX_IDLE = 2'h0, TX_RUN = 2'h1, TX_STOP = 2'h3, TX_SHIFT = 2'h2
    } uaf_tx_st_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } uaf_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } uaf_axi_rsp_t;

    typedef struct packed {
        uaf_axi_rsp_t rsp;
        logic awh, wh, wst;
        logic [7:0] awa, wd;
        logic sm0, sm1, mp, ren, tb8, rb8, ti, ri, fe;
        logic dbl, fcs, rxc, txc;
        logic [7:0] own, msk, rbuf;
        logic [2:0] ist, imsk;
        logic t1h, rx_prev;
        logic [1:0] m2c;
        logic [3:0] m0c;
        uaf_rx_st_t rst;
        logic [3:0] rcnt, rbit;
        logic [7:0] rsh;
        logic r9;
        uaf_tx_st_t tst;
        logic [3:0] tcnt, tleft;
        logic [10:0] tsh;
        logic txd, dout, doe, irq;
    } uaf_st_t;
endpackage : uaf_pkg

// ---- logic/uaf_uart.sv ----
`timescale 1ns/1ps
module uaf_uart
    import uaf_pkg::*;
(
    input logic ref_clk,
    input logic arst_n,
    input uaf_axi_req_t axi_req,
    output uaf_axi_rsp_t axi_rsp,
    input logic rxd_in,
    input logic t1_ovf,
    input logic t2_ovf,
    output logic txd,
    output logic data_out,
    output logic data_oe,
    output logic irq
);
    uaf_st_t q;
    uaf_st_t n;
    logic [1:0] mode;
    logic m2t, t1t, rtk, ttk, m0e, rsamp;
    logic wr, rd, ctl_wr, fe_wr, txgo, fin, b9, stop_ok;
    logic [7:0] wv, rv;

    // Baud tick of one direction; mode 2 uses the fixed divider
    function automatic logic btick(input logic [1:0] md, input logic sel,
                                   input logic m2, input logic t1,
                                   input logic t2);
        if (md == MODE2)
        begin
            return m2;
        end
        return sel ? t2 : t1;
    endfunction : btick

    // Given or broadcast address match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] own,
                                 input logic [7:0] msk);
        logic [7:0] bc;
        bc = own | msk;
        return (((a ^ own) & msk) == ADDR_RST)
            || (((a ^ bc) & bc) == ADDR_RST);
    endfunction : hit

    // Offset lies on the register map
    function automatic logic mapped(input logic [7:0] a);
        return (a <= OFS_IMSK) && (a[1:0] == 2'h0);
    endfunction : mapped

    assign axi_rsp = q.rsp;
    assign txd = q.txd;
    assign data_out = q.dout;
    assign data_oe = q.doe;
    assign irq = q.irq;

    // Next-state logic for the whole block
    always_comb
    begin
        n = q;
        mode = {q.sm0, q.sm1};
        wv = q.wd;
        rv = 8'h00;
        fin = 1'b0;
        b9 = 1'b0;
        stop_ok = 1'b1;
        // Baud ticks, independent per direction except in mode 2
        m2t = (q.m2c == (q.dbl ? M2_DIV_DBL : M2_DIV));
        n.m2c = m2t ? 2'h0 : q.m2c + 2'h1;
        if (t1_ovf)
        begin
            n.t1h = ~q.t1h;
        end
        t1t = t1_ovf & (q.dbl | q.t1h);
        rtk = btick(mode, q.rxc, m2t, t1t, t2_ovf);
        ttk = btick(mode, q.txc, m2t, t1t, t2_ovf);
        m0e = (q.m0c == M0_LAST);
        n.m0c = m0e ? 4'h0 : q.m0c + 4'h1;
        // Bus channel bookkeeping
        if (q.rsp.bvalid && axi_req.bready)
        begin
            n.rsp.bvalid = 1'b0;
        end
        if (q.rsp.rvalid && axi_req.rready)
        begin
            n.rsp.rvalid = 1'b0;
        end
        if (axi_req.awvalid && q.rsp.awready)
        begin
            n.awh = 1'b1;
            n.awa = axi_req.awaddr;
        end
        if (axi_req.wvalid && q.rsp.wready)
        begin
            n.wh = 1'b1;
            n.wd = axi_req.wdata[7:0];
            n.wst = axi_req.wstrb[0];
        end
        wr = q.awh && q.wh && !q.rsp.bvalid;
        rd = axi_req.arvalid && q.rsp.arready;
        ctl_wr = wr && q.wst && (q.awa == OFS_CTRL);
        fe_wr = ctl_wr && q.fcs;
        txgo = wr && q.wst && (q.awa == OFS_DATA);
        // Software writes; hardware sets below override clears
        if (wr)
        begin
            n.awh = 1'b0;
            n.wh = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp = mapped(q.awa) ? RESP_OK : RESP_ERR;
            if (q.wst)
            begin
                case (q.awa)
                    OFS_CTRL:
                    begin
                        if (q.fcs)
                        begin
                            n.fe = wv[CB_TOP];
                        end
                        else
                        begin
                            n.sm0 = wv[CB_TOP];
                        end
                        n.sm1 = wv[CB_SM1];
                        n.mp = wv[CB_MP];
                        n.ren = wv[CB_REN];
                        n.tb8 = wv[CB_TB8];
                        n.rb8 = wv[CB_RB8];
                        n.ti = wv[CB_TI];
                        n.ri = wv[CB_RI];
                    end
                    OFS_PWR:
                    begin
                        n.dbl = wv[PB_DBL];
                        n.fcs = wv[PB_FCS];
                    end
                    OFS_OWN: n.own = wv;
                    OFS_MASK: n.msk = wv;
                    OFS_CSEL:
                    begin
                        n.rxc = wv[SB_RXC];
                        n.txc = wv[SB_TXC];
                    end
                    OFS_IMSK: n.imsk = wv[2:0];
                    default: n.own = q.own;
                endcase
            end
        end
        // Register reads; status is cleared by its read
        if (rd)
        begin
            case (axi_req.araddr)
                OFS_CTRL:
                begin
                    rv[CB_TOP] = q.fcs ? q.fe : q.sm0;
                    rv[CB_SM1] = q.sm1;
                    rv[CB_MP] = q.mp;
                    rv[CB_REN] = q.ren;
                    rv[CB_TB8] = q.tb8;
                    rv[CB_RB8] = q.rb8;
                    rv[CB_TI] = q.ti;
                    rv[CB_RI] = q.ri;
                end
                OFS_PWR:
                begin
                    rv[PB_DBL] = q.dbl;
                    rv[PB_FCS] = q.fcs;
                end
                OFS_DATA: rv = q.rbuf;
                OFS_OWN: rv = q.own;
                OFS_MASK: rv = q.msk;
                OFS_CSEL:
                begin
                    rv[SB_RXC] = q.rxc;
                    rv[SB_TXC] = q.txc;
                end
                OFS_IST:
                begin
                    rv[2:0] = q.ist;
                    n.ist = 3'h0;
                end
                OFS_IMSK: rv[2:0] = q.imsk;
                default: rv = 8'h00;
            endcase
            n.rsp.rvalid = 1'b1;
            n.rsp.rdata = {24'h000000, rv};
            n.rsp.rresp = mapped(axi_req.araddr) ? RESP_OK : RESP_ERR;
        end
        // Transmitter; a data write while busy is dropped
        case (q.tst)
            TX_IDLE:
            begin
                if (txgo && mode == MODE0 && q.rst != RX_SHIFT)
                begin
                    n.tst = TX_SHIFT;
                    n.m0c = 4'h0;
                    n.doe = 1'b1;
                    n.dout = wv[0];
                    n.tsh = {4'h0, wv[7:1]};
                    n.tleft = BIT_LAST;
                end
                else if (txgo && mode != MODE0)
                begin
                    n.tst = TX_RUN;
                    n.tcnt = 4'h0;
                    n.tsh = q.sm0 ? {1'b1, q.tb8, wv, 1'b0}
                                  : {2'h3, wv, 1'b0};
                    n.tleft = q.sm0 ? FR_LEN9 : FR_LEN8;
                end
            end
            TX_RUN:
            begin
                if (ttk)
                begin
                    n.tcnt = q.tcnt + 4'h1;
                    if (q.tcnt == 4'h0)
                    begin
                        n.txd = q.tsh[0];
                        n.tsh = q.tsh >> 1;
                        n.tleft = q.tleft - 4'h1;
                        if (q.tleft == FR_STOP)
                        begin
                            n.tst = TX_STOP;
                            n.ti = 1'b1;
                            n.ist[IB_TX] = 1'b1;
                        end
                    end
                end
            end
            TX_STOP:
            begin
                if (ttk)
                begin
                    n.tcnt = q.tcnt + 4'h1;
                    if (q.tcnt == OS_LAST)
                    begin
                        n.tst = TX_IDLE;
                    end
                end
            end
            TX_SHIFT:
            begin
                if (m0e && q.tleft == 4'h0)
                begin
                    n.tst = TX_IDLE;
                    n.doe = 1'b0;
                    n.ti = 1'b1;
                    n.ist[IB_TX] = 1'b1;
                end
                else if (m0e)
                begin
                    n.dout = q.tsh[0];
                    n.tsh = q.tsh >> 1;
                    n.tleft = q.tleft - 4'h1;
                end
            end
            default: n.tst = TX_IDLE;
        endcase
        // Receiver, sampling at mid bit on the sixteen-times tick in modes 1 to 3
        n.rx_prev = rxd_in;
        if (rtk)
        begin
            n.rcnt = q.rcnt + 4'h1;
        end
        rsamp = rtk && (q.rcnt == OS_LAST);
        case (q.rst)
            RX_IDLE:
            begin
                if (q.ren && mode == MODE0 && !q.ri && q.tst == TX_IDLE)
                begin
                    n.rst = RX_SHIFT;
                    n.m0c = 4'h0;
                    n.rbit = 4'h0;
                end
                else if (q.ren && mode != MODE0 && q.rx_prev && !rxd_in)
                begin
                    n.rst = RX_START;
                    n.rcnt = 4'h0;
                end
            end
            RX_START:
            begin
                if (rtk && q.rcnt == OS_MID)
                begin
                    n.rst = rxd_in ? RX_IDLE : RX_DATA;
                    n.rcnt = 4'h0;
                    n.rbit = 4'h0;
                end
            end
            RX_DATA:
            begin
                if (rsamp)
                begin
                    n.rsh = {rxd_in, q.rsh[7:1]};
                    n.rbit = q.rbit + 4'h1;
                    if (q.rbit == BIT_LAST)
                    begin
                        n.rst = q.sm0 ? RX_NINE : RX_STOP;
                    end
                end
            end
            RX_NINE:
            begin
                if (rsamp)
                begin
                    n.r9 = rxd_in;
                    n.rst = q.fcs ? RX_STOP : RX_IDLE;
                    fin = !q.fcs;
                    b9 = rxd_in;
                end
            end
            RX_STOP:
            begin
                if (rsamp)
                begin
                    n.rst = RX_IDLE;
                    fin = 1'b1;
                    stop_ok = rxd_in;
                    b9 = q.sm0 ? q.r9 : rxd_in;
                    if (q.fcs && !rxd_in)
                    begin
                        n.fe = 1'b1;
                        n.ist[IB_FE] = 1'b1;
                    end
                end
            end
            RX_SHIFT:
            begin
                if (m0e)
                begin
                    n.rsh = {rxd_in, q.rsh[7:1]};
                    n.rbit = q.rbit + 4'h1;
                    if (q.rbit == BIT_LAST)
                    begin
                        n.rst = RX_IDLE;
                        n.rbuf = {rxd_in, q.rsh[7:1]};
                        n.ri = 1'b1;
                        n.ist[IB_RX] = 1'b1;
                    end
                end
            end
            default: n.rst = RX_IDLE;
        endcase
        // Frame acceptance with address filtering
        if (fin && !q.ri)
        begin
            if (!q.mp || (b9 && stop_ok && hit(q.rsh, q.own, q.msk)))
            begin
                n.rbuf = q.rsh;
                n.rb8 = b9;
                n.ri = 1'b1;
                n.ist[IB_RX] = 1'b1;
            end
        end
        // Shift clock on txd while mode 0 shifts
        if (n.tst == TX_SHIFT || n.rst == RX_SHIFT)
        begin
            n.txd = (n.m0c >= M0_HALF);
        end
        else if (mode == MODE0)
        begin
            n.txd = TXD_IDLE;
        end
        n.rsp.awready = !n.awh;
        n.rsp.wready = !n.wh;
        n.rsp.arready = !n.rsp.rvalid;
        n.irq = |(n.ist & n.imsk);
    end

    // State register; reset leaves both addresses at zero
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '0;
            q.txd <= TXD_IDLE;
            q.rx_prev <= TXD_IDLE;
        end
        else
        begin
            q <= n;
        end
    end

    a_fe_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
        q.fe && !fe_wr |=> q.fe)
        else $error("framing error flag dropped without software");
    a_fe_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(q.fe) && !$past(fe_wr) |-> $past(q.fcs))
        else $error("framing error set while checks off");
    a_fe_cause: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(q.fe) && !$past(fe_wr)
        |-> $past(q.rst) == RX_STOP && !$past(rxd_in))
        else $error("framing error without a low stop bit");
    a_ri_at_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(q.ri) && !$past(ctl_wr) && $past(q.fcs) && q.sm0
        |-> $past(q.rst) == RX_STOP)
        else $error("receive done not at stop bit");
    a_addr_filter: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(q.ri) && !$past(ctl_wr) && $past(q.mp) && mode != MODE0
        |-> q.rb8 && hit(q.rbuf, q.own, q.msk))
        else $error("unmatched command frame accepted");
    a_mode1_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(q.ri) && !$past(ctl_wr) && $past(q.mp) && mode == 2'h1
        |-> $past(rxd_in))
        else $error("mode 1 address accepted with bad stop");
    a_mode0_nofilt: assert property (@(posedge ref_clk) disable iff (!arst_n)
        q.rst == RX_SHIFT && m0e && q.rbit == BIT_LAST
        |=> q.ri && q.rst == RX_IDLE)
        else $error("mode 0 byte not delivered");
    a_tx_tick: assert property (@(posedge ref_clk) disable iff (!arst_n)
        q.tst == TX_RUN && !ttk |=> $stable(q.tcnt))
        else $error("transmitter moved without its tick");
    a_rx_tick: assert property (@(posedge ref_clk) disable iff (!arst_n)
        q.rst == RX_DATA && !rtk |=> $stable(q.rcnt))
        else $error("receiver moved without its tick");
    a_ti_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(q.ti) && !$past(ctl_wr) && mode != MODE0
        |-> q.tst == TX_STOP && q.txd)
        else $error("transmit done not at stop bit");
endmodule : uaf_uart

// ---- verification/uaf_peer.sv ----
`timescale 1ns/1ps
module uaf_peer
(
    input logic ref_clk,
    input logic txd,
    output logic rxd_out,
    output logic in_stop
);
    // Line idles high between frames
    initial
    begin
        rxd_out = 1'b1;
        in_stop = 1'b0;
    end

    // Start, data LSB first, optional ninth bit, then stop bit
    task automatic send(input logic [7:0] d, input logic has9,
                        input logic b9, input logic stp, input int per);
        logic [10:0] f;
        int n;
        f = has9 ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        n = has9 ? 11 : 10;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            rxd_out <= f[i];
            in_stop <= (i == n - 1);
            repeat (per - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rxd_out <= 1'b1;
        in_stop <= 1'b0;
    endtask : send

    // Samples one transmitted frame in mid bit
    task automatic get(input int per, output logic [7:0] d);
        @(negedge txd);
        repeat (per / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (per) @(posedge ref_clk);
            d[i] = txd;
        end
    endtask : get
endmodule : uaf_peer

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench
    import uaf_pkg::*;
;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    uaf_axi_req_t req = '0;
    uaf_axi_rsp_t rsp;
    logic rxd, txd, dout, doe, irq, stp;
    int err_count = 0;
    int comparisons = 0;
    int tc = 0;

    // Clock; timer 2 overflows every 2 clocks, timer 1 every 3
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        tc <= (tc == 5) ? 0 : tc + 1;
        t2 <= tc[0];
        t1 <= (tc == 0) || (tc == 3);
    end

    uaf_uart dut (.ref_clk(ref_clk), .arst_n(arst_n), .axi_req(req),
        .axi_rsp(rsp), .rxd_in(rxd), .t1_ovf(t1), .t2_ovf(t2),
        .txd(txd), .data_out(dout), .data_oe(doe), .irq(irq));
    uaf_peer peer (.ref_clk(ref_clk), .txd(txd), .rxd_out(rxd),
        .in_stop(stp));

    task automatic chk(input logic [31:0] s, input logic [31:0] e,
                       input string m);
        comparisons++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD t=%0t %s seen %0h want %0h", $time, m, s, e);
        end
    endtask : chk

    // Register write: address and data offered together
    task automatic axw(input logic [7:0] a, input logic [7:0] d,
                       output logic [1:0] r);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end
        while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        req.bready <= 1'b0;
        // Let an edge pass so a following call never reassigns bready now
        @(posedge ref_clk);
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end
        while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        // Let an edge pass so a following call never reassigns rready now
        @(posedge ref_clk);
    endtask : axr

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk({30'h0, r}, {30'h0, RESP_OK}, "write resp");
    endtask : wr

    // Read, then compare the bits under mask m
    task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(d & {24'h0, m}, {24'h0, e}, "read data");
        chk({30'h0, r}, {30'h0, RESP_OK}, "read resp");
    endtask : rdc

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rdc(OFS_OWN, 8'hFF, ADDR_RST);
        rdc(OFS_MASK, 8'hFF, ADDR_RST);
        axr(8'h20, d, r);
        chk({30'h0, r}, {30'h0, RESP_ERR}, "unmapped read");
        axw(8'h20, 8'h5A, r);
        chk({30'h0, r}, {30'h0, RESP_ERR}, "unmapped write");
        wr(OFS_OWN, 8'hA3);
        rdc(OFS_OWN, 8'hFF, 8'hA3);
        $display("test regs done");
    endtask : t_regs

    // Mode 3 address frames against own address and mask
    task automatic t_addr();
        logic [7:0] ta [7] = '{8'h00, 8'h56, 8'h56, 8'h56, 8'h56, 8'h56,
                               8'h56};
        logic [7:0] tm [7] = '{8'h00, 8'hFC, 8'hFC, 8'hFC, 8'hFC, 8'hFF,
                               8'hFF};
        logic [7:0] tx [7] = '{8'h3C, 8'h57, 8'h5A, 8'hFE, 8'h57, 8'h57,
                               8'hFF};
        logic tn [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        logic te [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        wr(OFS_CSEL, 8'h03);
        wr(OFS_IMSK, 8'h01);
        for (int i = 0; i < 7; i++)
        begin
            wr(OFS_OWN, ta[i]);
            wr(OFS_MASK, tm[i]);
            wr(OFS_CTRL, 8'hF0);
            peer.send(tx[i], 1'b1, tn[i], 1'b1, 32);
            chk({31'h0, irq}, {31'h0, te[i]}, "irq");
            rdc(OFS_IST, 8'h01, {7'h0, te[i]});
        end
        wr(OFS_CTRL, 8'hD0);
        peer.send(8'h5A, 1'b1, 1'b0, 1'b1, 32);
        rdc(OFS_CTRL, 8'h01, 8'h01);
        wr(OFS_CTRL, 8'h30);
        repeat (120) @(posedge ref_clk);
        rdc(OFS_CTRL, 8'h01, 8'h01);
        rdc(OFS_DATA, 8'hFF, 8'hFF);
        $display("test addr done");
    endtask : t_addr

    task automatic t_frame();
        wr(OFS_CTRL, 8'h50);
        wr(OFS_PWR, 8'h40);
        peer.send(8'hA5, 1'b0, 1'b0, 1'b0, 32);
        rdc(OFS_IST, 8'h05, 8'h05);
        rdc(OFS_DATA, 8'hFF, 8'hA5);
        wr(OFS_PWR, 8'h00);
        rdc(OFS_CTRL, 8'h80, 8'h00);
        wr(OFS_PWR, 8'h40);
        rdc(OFS_CTRL, 8'h80, 8'h80);
        wr(OFS_CTRL, 8'hD0);
        peer.send(8'h3C, 1'b0, 1'b0, 1'b1, 32);
        rdc(OFS_CTRL, 8'h81, 8'h81);
        wr(OFS_CTRL, 8'h50);
        rdc(OFS_CTRL, 8'h80, 8'h00);
        wr(OFS_PWR, 8'h00);
        peer.send(8'h3C, 1'b0, 1'b0, 1'b0, 32);
        wr(OFS_CTRL, 8'h50);
        wr(OFS_PWR, 8'h40);
        rdc(OFS_CTRL, 8'h80, 8'h00);
        wr(OFS_OWN, 8'h56);
        wr(OFS_MASK, 8'hFF);
        wr(OFS_CTRL, 8'h70);
        peer.send(8'h56, 1'b0, 1'b0, 1'b0, 32);
        rdc(OFS_CTRL, 8'h01, 8'h00);
        peer.send(8'h56, 1'b0, 1'b0, 1'b1, 32);
        rdc(OFS_CTRL, 8'h01, 8'h01);
        $display("test frame done");
    endtask : t_frame

    // Receive done at ninth bit, or at stop bit with checking on
    task automatic t_rdone();
        wr(OFS_PWR, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_CTRL, 8'hD0);
            wr(OFS_PWR, (k == 1) ? 8'h40 : 8'h00);
            rdc(OFS_IST, 8'h00, 8'h00);
            fork
                peer.send(8'h81, 1'b1, 1'b0, 1'b1, 32);
                begin
                    @(posedge stp);
                    repeat (3) @(posedge ref_clk);
                    chk({31'h0, irq}, {31'h0, k == 0}, "early");
                end
            join
            chk({31'h0, irq}, 32'h1, "rx done");
        end
        $display("test rdone done");
    endtask : t_rdone

    // Both directions at once, each on its own timer
    task automatic t_duplex();
        logic [7:0] v;
        wr(OFS_PWR, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            wr(OFS_CTRL, 8'h50);
            wr(OFS_CSEL, (k == 1) ? 8'h02 : 8'h01);
            fork
                peer.send((k == 1) ? 8'h3B : 8'h3A, 1'b0, 1'b0, 1'b1,
                          (k == 1) ? 96 : 32);
                peer.get((k == 1) ? 32 : 96, v);
                wr(OFS_DATA, (k == 1) ? 8'hC4 : 8'hC5);
            join
            chk({24'h0, v}, (k == 1) ? 32'hC4 : 32'hC5, "tx");
            rdc(OFS_DATA, 8'hFF, (k == 1) ? 8'h3B : 8'h3A);
            // Let the stop bit finish; a data write while busy is dropped
            repeat (160) @(posedge ref_clk);
            rdc(OFS_CTRL, 8'h02, 8'h02);
        end
        // Mode 2 reception on the fixed divider
        wr(OFS_CTRL, 8'h90);
        peer.send(8'h69, 1'b1, 1'b1, 1'b1, 64);
        rdc(OFS_DATA, 8'hFF, 8'h69);
        rdc(OFS_CTRL, 8'h04, 8'h04);
        // Mode 0 transmit: data pin driven, shift clock low in first half
        wr(OFS_CTRL, 8'h00);
        v = 8'h5A;
        wr(OFS_DATA, v);
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            chk({29'h0, doe, dout, txd}, {29'h0, 1'b1, v[i], 1'b0}, "shift");
            repeat (12) @(posedge ref_clk);
        end
        chk({31'h0, doe}, 32'h0, "data pin released");
        rdc(OFS_CTRL, 8'h02, 8'h02);
        chk({31'h0, irq}, 32'h1, "unmasked irq");
        wr(OFS_IMSK, 8'h00);
        chk({31'h0, irq}, 32'h0, "masked irq");
        rdc(OFS_IST, 8'h03, 8'h03);
        rdc(OFS_IST, 8'h07, 8'h00);
        $display("test duplex done");
    endtask : t_duplex

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // Reset, then the scenarios in turn
    initial
    begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_addr();
        t_frame();
        t_rdone();
        t_duplex();
        report_and_stop();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        report_and_stop();
    end
endmodule : testbench
